// [logic/eeu_exit_unit.sv]
/*
 * Asynchronous enclave exit unit with a classic Wishbone register slave.
 * Assumes the core captures i_ctx at each entry or resume, moves state
 * to and from memory on o_save_req and o_restore_req, and starts the
 * event handler only after o_handler_go.
 */
module eeu_exit_unit (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_wb_cyc,
  input wire logic i_wb_stb,
  input wire logic i_wb_we,
  input wire logic [7:0] i_wb_adr,
  input wire logic [31:0] i_wb_dat,
  input wire logic [3:0] i_wb_sel,
  output logic [31:0] o_wb_dat,
  output logic o_wb_ack,
  input wire logic i_event_valid,
  input wire eeu_pkg::eeu_event_t i_event,
  input wire logic i_mode64,
  input wire eeu_pkg::eeu_ctx_t i_ctx,
  input wire logic [63:0] i_flags,
  input wire logic [63:0] i_cr2,
  input wire logic i_save_done,
  input wire logic i_enter,
  input wire logic i_resume,
  input wire logic i_cache_invalidate_no_writeback,
  output logic o_save_req,
  output logic [63:0] o_save_addr,
  output logic o_save_fmt64,
  output logic o_synth_valid,
  output eeu_pkg::eeu_synth_t o_synth,
  output logic o_handler_go,
  output logic o_enclave_mode,
  output logic o_enter_ok,
  output logic o_enter_fail,
  output logic o_restore_req,
  output logic [63:0] o_restore_addr,
  output logic o_gp_fault,
  output logic [15:0] o_gp_code
);
  import eeu_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  typedef enum logic [1:0] {S_IDLE, S_SAVE, S_SYNTH, S_EXIT} eeu_state_t;

  eeu_state_t state_q;
  logic prm_q;
  logic mode_q;
  logic mode64_q;
  logic [SLOT_W-1:0] cur_q;
  logic [SLOT_W-1:0] cnt_q;
  logic [7:0] exits_q;
  eeu_event_t ev_q;
  eeu_synth_t synth_q;
  logic synth_v_q;
  logic save_req_q;
  logic [63:0] save_addr_q;
  logic handler_q;
  logic ok_q;
  logic fail_q;
  logic rst_req_q;
  logic [63:0] rst_addr_q;
  logic gp_q;
  logic ack_q;
  logic [31:0] rdat_q;
  logic [63:0] cur_addr;
  logic [63:0] prev_addr;
  logic [63:0] scrub_flags;
  logic [SLOT_W-1:0] prev_slot;
  logic bus_req;
  logic bus_wr;
  logic [31:0] wmask;
  logic [31:0] slot_word;
  logic [31:0] wslot;
  logic slot_hw;
  logic [63:0] fit_tcs;
  logic [63:0] fit_aep;
  logic [63:0] fit_sp;
  logic [63:0] fit_bp;
  logic [63:0] fit_cr2;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [63:0] fit(input logic [63:0] v,
                                      input logic m64);
    fit = m64 ? v : (v & LOW_WORD_MASK); // [RULE16]
  endfunction

  assign prev_slot = cur_q - 8'h01;

  eeu_frame_addr u_cur_frame (
    .i_base(i_ctx.base),
    .i_offset(i_ctx.offset),
    .i_pages(i_ctx.frame_pages),
    .i_slot(cur_q),
    .o_addr(cur_addr)
  );

  eeu_frame_addr u_prev_frame (
    .i_base(i_ctx.base),
    .i_offset(i_ctx.offset),
    .i_pages(i_ctx.frame_pages),
    .i_slot(prev_slot),
    .o_addr(prev_addr)
  );

  eeu_flag_scrub u_scrub (
    .i_flags(i_flags),
    .i_mode64(mode64_q),
    .o_flags(scrub_flags)
  );

  always_comb begin
    fit_tcs = fit(i_ctx.tcs_ptr, mode64_q);
    fit_aep = fit(i_ctx.async_exit_pointer, mode64_q);
    fit_sp = fit(i_ctx.usp, mode64_q);
    fit_bp = fit(i_ctx.ufp, mode64_q);
    fit_cr2 = fit(i_cr2 & FAULT_ADDR_KEEP, mode64_q);
  end

  // ****************************************************************
  // Wishbone slave
  // ****************************************************************
  assign bus_req = i_wb_cyc && i_wb_stb && !ack_q;
  assign bus_wr = bus_req && i_wb_we;
  assign wmask = {{8{i_wb_sel[3]}}, {8{i_wb_sel[2]}},
                  {8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
  assign slot_word = {16'h0000, cnt_q, cur_q};
  assign wslot = (slot_word & ~wmask) | (i_wb_dat & wmask);
  assign slot_hw = (state_q == S_SYNTH) ||
                   (state_q == S_IDLE && !i_event_valid &&
                    i_resume && mode_q == 1'b0 && cur_q != SLOT_CUR_RST);

  // Ack rises one cycle after the strobe and drops the cycle after.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= bus_req;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rdat_q <= 32'h00000000;
    end else if (bus_req && !i_wb_we) begin
      case (i_wb_adr)
        REG_CTRL: rdat_q <= {30'h0, mode_q, prm_q};
        REG_SLOT: rdat_q <= slot_word;
        REG_STAT: rdat_q <= {16'h0000, exits_q, 5'h00, ev_q.cause};
        default: rdat_q <= 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      prm_q <= 1'b0;
    end else if (bus_wr && i_wb_adr == REG_CTRL && i_wb_sel[0]) begin
      prm_q <= i_wb_dat[CTRL_PRM_BIT];
    end
  end

  // Hardware slot updates win over a software write in the same cycle,
  // since losing an exit would corrupt the frame stack.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cur_q <= SLOT_CUR_RST;
      cnt_q <= SLOT_CNT_RST;
    end else if (slot_hw) begin
      if (state_q == S_SYNTH) begin
        cur_q <= cur_q + 8'h01; // [RULE4]
      end else begin
        cur_q <= prev_slot; // [RULE22] [RULE20]
      end
    end else if (bus_wr && i_wb_adr == REG_SLOT) begin
      cur_q <= wslot[SLOT_CUR_LSB +: SLOT_W];
      cnt_q <= wslot[SLOT_CNT_LSB +: SLOT_W];
    end
  end

  // ****************************************************************
  // Exit sequence
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= S_IDLE;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (i_event_valid && mode_q) begin
            state_q <= S_SAVE;
          end
        end
        S_SAVE: begin
          if (i_save_done) begin
            state_q <= S_SYNTH; // [RULE3]
          end
        end
        S_SYNTH: state_q <= S_EXIT;
        S_EXIT: state_q <= S_IDLE;
        default: state_q <= S_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ev_q <= '0;
      mode64_q <= 1'b0;
    end else if (state_q == S_IDLE && i_event_valid && mode_q) begin
      ev_q <= i_event;
      mode64_q <= i_mode64;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      save_req_q <= 1'b0;
      save_addr_q <= 64'h0000000000000000;
    end else begin
      save_req_q <= state_q == S_IDLE && i_event_valid && mode_q;
      if (state_q == S_IDLE && i_event_valid && mode_q) begin
        save_addr_q <= cur_addr; // [RULE3] [RULE18]
      end
    end
  end

  // Synthetic state is computed only after the save has completed.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      synth_q <= '0;
      synth_v_q <= 1'b0;
    end else begin
      synth_v_q <= state_q == S_SYNTH;
      if (state_q == S_SYNTH) begin
        synth_q.ax <= RESUME_LEAF; // [RULE6]
        synth_q.bx <= fit_tcs; // [RULE6]
        synth_q.cx <= fit_aep; // [RULE6]
        synth_q.ip <= fit_aep; // [RULE5]
        synth_q.dx <= 64'h0000000000000000; // [RULE7]
        synth_q.si <= 64'h0000000000000000; // [RULE7]
        synth_q.di <= 64'h0000000000000000; // [RULE7]
        synth_q.clr_upper <= mode64_q; // [RULE7]
        synth_q.sp <= fit_sp; // [RULE8]
        synth_q.bp <= fit_bp; // [RULE8]
        synth_q.flags <= scrub_flags; // [RULE9]
        synth_q.init_mask <= X87_SSE_INIT_MASK; // [RULE10]
        synth_q.fpu_control_word <= (ev_q.cause == EV_FP_ERR) ?
                       FCW_FP_FAULT : FCW_DEFAULT; // [RULE11]
        synth_q.fpu_status_word <= (ev_q.cause == EV_FP_ERR) ?
                       FSW_FP_FAULT : FSW_DEFAULT; // [RULE12]
        synth_q.vcs <= (ev_q.cause == EV_SIMD_FP) ?
                       VCS_SIMD_FAULT : VCS_DEFAULT; // [RULE13]
        synth_q.cr2 <= fit_cr2; // [RULE14]
        synth_q.cr2_we <= ev_q.cause == EV_PAGE_FAULT &&
                          !ev_q.pf_vmexit &&
                          !ev_q.pf_in_delivery; // [RULE14]
        synth_q.fs <= fit(i_ctx.fs, mode64_q); // [RULE15] [RULE16]
        synth_q.gs <= fit(i_ctx.gs, mode64_q); // [RULE15] [RULE16]
        if (ev_q.ist_used) begin
          synth_q.stack <= STK_IST; // [RULE17]
        end else if (ev_q.priv_change) begin
          synth_q.stack <= STK_RING; // [RULE17]
        end else begin
          synth_q.stack <= STK_APP; // [RULE17]
        end
      end
    end
  end

  // Enclave mode drops in the cycle before the handler is released.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_q <= 1'b0;
    end else if (state_q == S_SYNTH) begin
      mode_q <= 1'b0; // [RULE2]
    end else if (state_q == S_IDLE && !mode_q && i_enter &&
                 cur_q < cnt_q) begin
      mode_q <= 1'b1; // [RULE19]
    end else if (slot_hw && state_q == S_IDLE) begin
      mode_q <= 1'b1; // [RULE20]
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      handler_q <= 1'b0;
      exits_q <= 8'h00;
    end else begin
      handler_q <= state_q == S_EXIT; // [RULE2]
      if (state_q == S_EXIT) begin
        exits_q <= exits_q + 8'h01;
      end
    end
  end

  // ****************************************************************
  // Entry, resume and cache invalidate
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      ok_q <= 1'b0;
      fail_q <= 1'b0;
    end else begin
      ok_q <= state_q == S_IDLE && !mode_q && i_enter &&
              cur_q < cnt_q; // [RULE19]
      fail_q <= state_q == S_IDLE && !mode_q && i_enter &&
                cur_q >= cnt_q; // [RULE19]
    end
  end

  // Resume with no occupied frame is refused; nothing is restored.
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      rst_req_q <= 1'b0;
      rst_addr_q <= 64'h0000000000000000;
    end else begin
      rst_req_q <= slot_hw && state_q == S_IDLE; // [RULE20]
      if (slot_hw && state_q == S_IDLE) begin
        rst_addr_q <= prev_addr; // [RULE20]
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      gp_q <= 1'b0;
    end else begin
      gp_q <= i_cache_invalidate_no_writeback && prm_q; // [RULE1]
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign o_wb_ack = ack_q;
  assign o_wb_dat = rdat_q;
  assign o_save_req = save_req_q;
  assign o_save_addr = save_addr_q;
  assign o_save_fmt64 = mode64_q; // [RULE21]
  assign o_synth_valid = synth_v_q;
  assign o_synth = synth_q;
  assign o_handler_go = handler_q;
  assign o_enclave_mode = mode_q;
  assign o_enter_ok = ok_q;
  assign o_enter_fail = fail_q;
  assign o_restore_req = rst_req_q;
  assign o_restore_addr = rst_addr_q;
  assign o_gp_fault = gp_q;
  assign o_gp_code = GP_ERROR_CODE; // [RULE1]

endmodule // eeu_exit_unit

// [logic/eeu_flag_scrub.sv]
/*
 * Flag scrubbing and mode fitting for the pushed flags image.
 * Assumes the flags input is the architectural value at the exit.
 */
module eeu_flag_scrub (
  input wire logic [63:0] i_flags,
  input wire logic i_mode64,
  output logic [63:0] o_flags
);
  import eeu_pkg::*;

  always_comb begin
    o_flags = i_flags & ~FLAGS_CLEAR_MASK; // [RULE9]
    if (!i_mode64) begin
      o_flags = o_flags & LOW_WORD_MASK; // [RULE16]
    end
  end

endmodule // eeu_flag_scrub

// [logic/eeu_frame_addr.sv]
/*
 * Linear address of one save frame.
 * Assumes frame page count and slot are stable while the result is used.
 */
module eeu_frame_addr (
  input wire logic [63:0] i_base,
  input wire logic [63:0] i_offset,
  input wire logic [15:0] i_pages,
  input wire logic [eeu_pkg::SLOT_W-1:0] i_slot,
  output logic [63:0] o_addr
);
  import eeu_pkg::*;

  logic [63:0] span;

  // A frame spans whole pages, so the slot stride is pages shifted.
  always_comb begin
    span = 64'({i_pages, 12'h000}) * 64'(i_slot); // [RULE18]
    o_addr = i_base + i_offset + span; // [RULE18]
  end

endmodule // eeu_frame_addr

// [logic/eeu_pkg.sv]
/*
 * Constants, types and register map of the enclave exit unit.
 * Assumes a core that hands in the thread context captured at enclave
 * entry and that performs the actual state save and restore transfers.
 */
// Overview of operation
// RULE1: Reserved memory active: cache invalidate raises protection fault.
// RULE2: Leave enclave mode before handler starts.
// RULE3: Save to current frame, then load synthetic values.
// RULE4: Increment current save slot after the save.
// RULE5: Instruction pointer takes the async exit pointer.
// RULE6: Accumulator three, base thread pointer, count pointer.
// RULE7: Zero data, index regs; upper regs in 64-bit.
// RULE8: Restore stack and frame pointers from untrusted copies.
// RULE9: Clear arithmetic and resume flags before push.
// RULE10: x87 and SSE state go to init.
// RULE11: Control word 037E on fp fault, else 037F.
// RULE12: Status word 8081 on fp fault, else zero.
// RULE13: Vector status 1F01 on simd fault, else 1FB0.
// RULE14: Plain page fault clears low twelve address bits.
// RULE15: Extra segments restored to values at last entry.
// RULE16: 32-bit mode applies only low 32 bits.
// RULE17: Exit stack chosen as in ordinary operation.
// RULE18: Frame address from base, offset, slot, page count.
// RULE19: Entry fails unless current slot below slot count.
// RULE20: Resume reloads current frame then releases it.
// RULE21: Extended state uses ordinary save layout.
// RULE22: Resume decrements the current save slot.
package eeu_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SLOT = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam int CTRL_PRM_BIT = 0;
  localparam int CTRL_MODE_BIT = 1;
  localparam int SLOT_CUR_LSB = 0;
  localparam int SLOT_CNT_LSB = 8;
  localparam int SLOT_W = 8;
  localparam logic [SLOT_W-1:0] SLOT_CUR_RST = 8'h00;
  localparam logic [SLOT_W-1:0] SLOT_CNT_RST = 8'h01;
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_EXITS_LSB = 8;

  // ****************************************************************
  // Synthetic values
  // ****************************************************************
  localparam logic [63:0] RESUME_LEAF = 64'h0000000000000003;
  localparam logic [15:0] FCW_FP_FAULT = 16'h037E;
  localparam logic [15:0] FCW_DEFAULT = 16'h037F;
  localparam logic [15:0] FSW_FP_FAULT = 16'h8081;
  localparam logic [15:0] FSW_DEFAULT = 16'h0000;
  localparam logic [31:0] VCS_SIMD_FAULT = 32'h00001F01;
  localparam logic [31:0] VCS_DEFAULT = 32'h00001FB0;
  localparam logic [1:0] X87_SSE_INIT_MASK = 2'h3;
  localparam logic [63:0] FLAGS_CLEAR_MASK = 64'h00000000000108D5;
  localparam logic [63:0] LOW_WORD_MASK = 64'h00000000FFFFFFFF;
  localparam logic [63:0] FAULT_ADDR_KEEP = 64'hFFFFFFFFFFFFF000;
  localparam int PAGE_SHIFT = 12;
  localparam logic [15:0] GP_ERROR_CODE = 16'h0000;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    EV_INTR, EV_NMI, EV_SMI, EV_VMEXIT, EV_FP_ERR, EV_SIMD_FP,
    EV_PAGE_FAULT, EV_OTHER_EXC
  } eeu_cause_t;

  typedef enum logic [1:0] {STK_APP, STK_RING, STK_IST} eeu_stack_t;

  typedef struct packed {
    eeu_cause_t cause;
    logic pf_vmexit;
    logic pf_in_delivery;
    logic priv_change;
    logic ist_used;
  } eeu_event_t;

  typedef struct packed {
    logic [63:0] tcs_ptr;
    logic [63:0] async_exit_pointer;
    logic [63:0] base;
    logic [63:0] offset;
    logic [15:0] frame_pages;
    logic [63:0] usp;
    logic [63:0] ufp;
    logic [63:0] fs;
    logic [63:0] gs;
  } eeu_ctx_t;

  typedef struct packed {
    logic [63:0] ax, bx, cx, dx, si, di, sp, bp, ip, flags, cr2;
    logic [63:0] fs, gs;
    logic [15:0] fpu_control_word, fpu_status_word;
    logic [31:0] vcs;
    logic [1:0] init_mask;
    logic clr_upper;
    logic cr2_we;
    eeu_stack_t stack;
  } eeu_synth_t;

endpackage : eeu_pkg

// [testbench/eeu_exit_unit_chk.sv]
/* Concurrent checks on the ports of the enclave exit unit.
   Assumes the core holds event, mode, context and flags stable from the
   event pulse until the handler starts. */
module eeu_exit_chk (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire eeu_pkg::eeu_event_t i_event,
  input wire logic i_mode64,
  input wire eeu_pkg::eeu_ctx_t i_ctx,
  input wire logic [63:0] i_flags,
  input wire logic i_save_done,
  input wire logic i_enter,
  input wire logic i_resume,
  input wire logic i_cache_invalidate_no_writeback,
  input wire logic o_synth_valid,
  input wire eeu_pkg::eeu_synth_t o_synth,
  input wire logic o_handler_go,
  input wire logic o_enclave_mode,
  input wire logic o_enter_ok,
  input wire logic o_enter_fail,
  input wire logic o_restore_req,
  input wire logic o_gp_fault,
  input wire logic [15:0] o_gp_code
);
  import eeu_pkg::*;
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // A 32-bit exit must not leak the upper halves of any value.
  function automatic logic [63:0] fit(input logic [63:0] v, input logic m);
    return m ? v : (v & LOW_WORD_MASK);
  endfunction
  property p_gp_fault;
    o_gp_fault |-> $past(i_cache_invalidate_no_writeback) && o_gp_code == GP_ERROR_CODE;
  endproperty
  a_gp_fault: assert property (p_gp_fault)
    else $error("protection fault without invalidate or bad code");
  property p_leave_first;
    o_synth_valid |-> !o_enclave_mode ##1 (o_handler_go && !o_enclave_mode);
  endproperty
  a_leave_first: assert property (p_leave_first)
    else $error("handler started before enclave mode dropped");
  property p_save_order;
    o_synth_valid |-> $past(i_save_done, 2);
  endproperty
  a_save_order: assert property (p_save_order)
    else $error("synthetic state loaded before save finished");
  property p_entry;
    o_enter_ok |-> $past(i_enter) && o_enclave_mode && !o_enter_fail;
  endproperty
  a_entry: assert property (p_entry)
    else $error("entry accepted without request or mode");
  property p_trampoline;
    o_synth_valid |-> o_synth.ip == fit(i_ctx.async_exit_pointer, i_mode64)
      && o_synth.cx == o_synth.ip;
  endproperty
  a_trampoline: assert property (p_trampoline)
    else $error("exit pointer not loaded");
  property p_gpr;
    o_synth_valid |-> o_synth.ax == RESUME_LEAF && o_synth.dx == 64'h0
      && o_synth.bx == fit(i_ctx.tcs_ptr, i_mode64) && o_synth.si == 64'h0
      && o_synth.di == 64'h0 && o_synth.clr_upper == i_mode64;
  endproperty
  a_gpr: assert property (p_gpr)
    else $error("synthetic general registers wrong");
  property p_stack_ptr;
    o_synth_valid |-> o_synth.sp == fit(i_ctx.usp, i_mode64)
      && o_synth.bp == fit(i_ctx.ufp, i_mode64);
  endproperty
  a_stack_ptr: assert property (p_stack_ptr)
    else $error("stack or frame pointer not restored");
  property p_flags;
    o_synth_valid |-> o_synth.flags == fit(i_flags & ~FLAGS_CLEAR_MASK,
      i_mode64);
  endproperty
  a_flags: assert property (p_flags)
    else $error("flags image wrong");
  property p_fpu;
    o_synth_valid |-> o_synth.init_mask == X87_SSE_INIT_MASK && o_synth.fpu_control_word
      == (i_event.cause == EV_FP_ERR ? FCW_FP_FAULT : FCW_DEFAULT);
  endproperty
  a_fpu: assert property (p_fpu)
    else $error("floating point synthetic state wrong");
  property p_restore;
    o_restore_req |-> $past(i_resume) && o_enclave_mode
      && !$past(o_enclave_mode);
  endproperty
  a_restore: assert property (p_restore)
    else $error("restore without resume or mode");
endmodule // eeu_exit_chk

bind eeu_exit_unit eeu_exit_chk u_chk (.i_clk, .i_rst_n, .i_event,
  .i_mode64, .i_ctx, .i_flags, .i_save_done, .i_enter, .i_resume, .i_cache_invalidate_no_writeback,
  .o_synth_valid, .o_synth, .o_handler_go, .o_enclave_mode, .o_enter_ok,
  .o_enter_fail, .o_restore_req, .o_gp_fault, .o_gp_code);

// [testbench/tb.sv]
/* Self-checking bench for the enclave exit unit.
   Plays the core and a Wishbone master; the thread context is constant. */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import eeu_pkg::*;
  // ****************************************************************
  // Stimulus and design
  // ****************************************************************
  logic i_clk = 1'h0, i_rst_n = 1'h0, i_wb_cyc = 1'h0, i_wb_stb = 1'h0;
  logic i_wb_we = 1'h0, i_event_valid = 1'h0, i_mode64 = 1'h0;
  logic i_save_done = 1'h0, i_enter = 1'h0, i_resume = 1'h0, i_cache_invalidate_no_writeback = 1'h0;
  logic [7:0] i_wb_adr = 8'h00;
  logic [31:0] i_wb_dat = 32'h0, o_wb_dat, rd;
  logic [3:0] i_wb_sel = 4'hF;
  eeu_event_t i_event = '0;
  eeu_ctx_t i_ctx = '{64'h1111222233334000, 64'hAAAABBBBCCCCD000,
    64'h0000000100000000, 64'h8000, 16'h2, 64'h7FFF0010, 64'h7FFF0080,
    64'hF5F5000011112222, 64'h6A6A000033334444};
  logic [63:0] i_flags = 64'hFFFFFFFFFFFFFFFF, i_cr2 = 64'h123456789ABCDEF5;
  logic o_wb_ack, o_save_req, o_save_fmt64, o_synth_valid, o_handler_go;
  logic o_enclave_mode, o_enter_ok, o_enter_fail, o_restore_req, o_gp_fault;
  logic [63:0] o_save_addr, o_restore_addr;
  logic [15:0] o_gp_code;
  eeu_synth_t o_synth;
  int fail_count = 0, tests_run = 0, n;
  localparam logic [63:0] FRAME0 = 64'h0000000100008000;
  localparam logic [63:0] FRAME1 = 64'h000000010000A000;
  always #2.5 i_clk = ~i_clk;
  eeu_exit_unit dut (.i_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we,
    .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_event_valid,
    .i_event, .i_mode64, .i_ctx, .i_flags, .i_cr2, .i_save_done, .i_enter,
    .i_resume, .i_cache_invalidate_no_writeback, .o_save_req, .o_save_addr, .o_save_fmt64,
    .o_synth_valid, .o_synth, .o_handler_go, .o_enclave_mode, .o_enter_ok,
    .o_enter_fail, .o_restore_req, .o_restore_addr, .o_gp_fault, .o_gp_code);
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string what);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [63:0] fit(input logic [63:0] v, input logic m);
    return m ? v : (v & 64'h00000000FFFFFFFF);
  endfunction
  function automatic logic sig(input int k);
    return k == 0 ? o_wb_ack : k == 1 ? o_save_req : o_synth_valid;
  endfunction
  // Every wait is bounded so that a silent design cannot hang the run.
  task automatic await(input int k);
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (sig(k) !== 1'h1 && n < 40);
    if (sig(k) !== 1'h1) begin
      fail_count++;
      $display("ERROR t=%0t timeout waiting on %0d", $time, k);
      print_verdict();
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clk);
    i_wb_cyc <= 1'h1;
    i_wb_stb <= 1'h1;
    i_wb_we <= we;
    i_wb_adr <= a;
    i_wb_dat <= d;
    await(0);
    rd = o_wb_dat;
    i_wb_cyc <= 1'h0;
    i_wb_stb <= 1'h0;
  endtask
  task automatic pulse(input int k);
    @(posedge i_clk);
    case (k)
      0: i_enter <= 1'h1;
      1: i_resume <= 1'h1;
      2: i_cache_invalidate_no_writeback <= 1'h1;
      default: i_event_valid <= 1'h1;
    endcase
    @(posedge i_clk);
    {i_enter, i_resume, i_cache_invalidate_no_writeback, i_event_valid} <= 4'h0;
    @(posedge i_clk);
  endtask
  task automatic async_enclave_exit(input int i, input logic [63:0] addr);
    eeu_cause_t c;
    logic m, vm, dl, pf;
    c = (i < 8) ? eeu_cause_t'(i[2:0]) : EV_PAGE_FAULT;
    m = i[0];
    vm = (i == 8);
    dl = (i == 9);
    pf = (c == EV_PAGE_FAULT) && !vm && !dl;
    @(posedge i_clk);
    i_event <= '{c, vm, dl, i[1], i[2]};
    i_mode64 <= m;
    i_event_valid <= 1'h1;
    @(posedge i_clk);
    i_event_valid <= 1'h0;
    await(1);
    chk(o_save_addr, addr, "frame address");
    chk(o_save_fmt64, m, "save layout");
    i_save_done <= 1'h1;
    @(posedge i_clk);
    i_save_done <= 1'h0;
    await(2);
    chk(o_enclave_mode, 1'h0, "mode at exit");
    chk(o_synth.ip, fit(i_ctx.async_exit_pointer, m), "ip");
    chk(o_synth.ax, 64'h3, "ax");
    chk(o_synth.fpu_control_word, c == EV_FP_ERR ? 16'h037E : 16'h037F, "fcw");
    chk(o_synth.fpu_status_word, c == EV_FP_ERR ? 16'h8081 : 16'h0000, "fsw");
    chk(o_synth.vcs, c == EV_SIMD_FP ? 32'h1F01 : 32'h1FB0, "vcs");
    chk(o_synth.cr2_we, pf, "fault address update");
    if (pf) chk(o_synth.cr2, fit(i_cr2 & 64'hFFFFFFFFFFFFF000, m), "cr2");
    chk(o_synth.stack, i[2] ? STK_IST : i[1] ? STK_RING : STK_APP, "stk");
    chk(o_synth.gs, fit(i_ctx.gs, m), "gs");
    chk(o_synth.fs, fit(i_ctx.fs, m), "fs");
    @(posedge i_clk);
    chk(o_handler_go, 1'h1, "handler start");
  endtask
  initial begin
    repeat (16) @(posedge i_clk);
    i_rst_n <= 1'h1;
    wb(1'h0, 8'h04, 32'h0);
    chk(rd, 32'h0100, "slot reset");
    wb(1'h1, 8'h0C, 32'hFFFFFFFF);
    wb(1'h0, 8'h0C, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    pulse(3);
    chk(o_save_req, 1'h0, "event outside enclave");
    pulse(1);
    chk(o_restore_req, 1'h0, "resume with no frame");
    pulse(2);
    chk(o_gp_fault, 1'h0, "invalidate unprotected");
    wb(1'h1, 8'h00, 32'h3);
    wb(1'h0, 8'h00, 32'h0);
    chk(rd, 32'h1, "mode bit read only");
    pulse(2);
    chk(o_gp_fault, 1'h1, "invalidate protected");
    $display("test reset and refusals done");
    wb(1'h1, 8'h04, 32'h0200);
    pulse(0);
    chk(o_enter_ok, 1'h1, "enter");
    for (int i = 0; i < 10; i++) begin
      async_enclave_exit(i, FRAME0);
      wb(1'h0, 8'h04, 32'h0);
      chk(rd, 32'h0201, "slot after exit");
      pulse(1);
      chk(o_restore_addr, FRAME0, "resume frame");
      wb(1'h0, 8'h04, 32'h0);
      chk(rd, 32'h0200, "slot after resume");
    end
    wb(1'h0, 8'h08, 32'h0);
    chk(rd, 32'h0A06, "exit status");
    $display("test cause table done");
    async_enclave_exit(0, FRAME0);
    pulse(0);
    chk(o_enter_ok, 1'h1, "enter second frame");
    async_enclave_exit(5, FRAME1);
    pulse(0);
    chk(o_enter_fail, 1'h1, "enter with no frame");
    pulse(1);
    chk(o_restore_addr, FRAME1, "resume last frame");
    $display("test frame stack done");
    print_verdict();
  end
endmodule // tb
